/* File: logic/dram_tmg_pkg.sv */
package dram_tmg_pkg;
	// register map (byte addresses)
	localparam logic [11:0] OFF_TIMING_SECOND = 12'h08c;
	localparam logic [11:0] OFF_CONFIG_FIRST = 12'h090;
	localparam logic [11:0] OFF_SCHED_STATUS = 12'h098;
	localparam logic [31:0] RST_TIMING_SECOND = 32'h0000_0000;
	localparam logic [31:0] RST_CONFIG_FIRST = 32'h0000_0000;
	// writable bit masks
	localparam logic [31:0] MASK_TIMING_SECOND = 32'hfff7_fff0 & ~32'h0000_0080;
	localparam logic [31:0] MASK_CONFIG_FIRST = 32'h0009_ffb3;
	// timing-second field positions
	localparam int RWT_LO = 4;
	localparam int WTR_LO = 8;
	localparam int WRRD_LO = 10;
	localparam int WRWR_LO = 12;
	localparam int RDRD_LO = 14;
	localparam int REF_LO = 16;
	localparam int REF_OFF_BIT = 18;
	localparam int RFC_LO = 20;
	localparam int RFC_W = 3;
	// config-first field positions
	localparam int INIT_BIT = 0;
	localparam int SREX_BIT = 1;
	localparam int ODT_LO = 4;
	localparam int WEAK_BIT = 7;
	localparam int PAR_BIT = 8;
	localparam int FSR_BIT = 9;
	localparam int SHORT_BIT = 10;
	localparam int WIDE_BIT = 11;
	localparam int NARROW_LO = 12;
	localparam int UNREG_BIT = 16;
	localparam int ECC_BIT = 19;
	// code bases of spacing fields
	localparam logic [3:0] RWT_BASE = 4'h2;
	localparam logic [3:0] WRWR_BASE = 4'h1;
	localparam logic [3:0] RDRD_BASE = 4'h2;
	// refresh figures, link clock 8 MHz (125 ns)
	localparam int LINK_PERIOD_PS = 125000;
	localparam int REF_78_PS = 7800000;
	localparam int REF_39_PS = 3900000;
	localparam logic [7:0] REF_78_CYC = 8'(REF_78_PS / LINK_PERIOD_PS);
	localparam logic [7:0] REF_39_CYC = 8'(REF_39_PS / LINK_PERIOD_PS);
	localparam int RFC0_PS = 75000;
	localparam int RFC1_PS = 105000;
	localparam int RFC2_PS = 127500;
	localparam int RFC3_PS = 195000;
	localparam int RFC4_PS = 327500;
	localparam logic [3:0] RFC0_CYC = 4'((RFC0_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
	localparam logic [3:0] RFC1_CYC = 4'((RFC1_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
	localparam logic [3:0] RFC2_CYC = 4'((RFC2_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
	localparam logic [3:0] RFC3_CYC = 4'((RFC3_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
	localparam logic [3:0] RFC4_CYC = 4'((RFC4_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
	// init and self-refresh-exit sequence length in link cycles
	localparam logic [5:0] INIT_SEQ_CYC = 6'h20;
	localparam logic [5:0] SREX_SEQ_CYC = 6'h08;
	// burst lengths in beats
	localparam logic [3:0] BL_LONG = 4'h8;
	localparam logic [3:0] BL_SHORT = 4'h4;
	// command kinds
	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_READ = 3'b001,
		CMD_WRITE = 3'b010,
		CMD_ACT = 3'b011,
		CMD_REF = 3'b100
	} cmd_t;
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_INIT = 2'b01,
		SEQ_SREX = 2'b10
	} seq_t;
endpackage : dram_tmg_pkg

/* File: logic/cdc_pulse.sv */
`timescale 1ns/10ps
`default_nettype none
module cdc_pulse (
	// source side
	input wire logic src_clk,
	input wire logic src_rst,
	input wire logic src_pulse,
	// destination side
	input wire logic dst_clk,
	input wire logic dst_rst,
	output logic dst_pulse
);
	logic tgl_r;
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge src_clk) begin
		if (src_rst) begin
			tgl_r <= 1'b0;
		end else if (src_pulse) begin
			tgl_r <= ~tgl_r;
		end
	end

	always_ff @(posedge dst_clk) begin
		if (dst_rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= tgl_r;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign dst_pulse = s2_r ^ s3_r;
endmodule : cdc_pulse
`default_nettype wire

/* File: logic/dram_timing_refresh_config.sv */
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module dram_timing_refresh_config (
	// system
	input wire logic sys_clk,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// link side
	input wire logic mem_clk,
	input wire logic mem_rst,
	input wire logic [2:0] cand_cmd,
	input wire logic [2:0] cand_cs,
	input wire logic cand_odt_change,
	output logic cand_grant,
	output logic refresh_req,
	output logic emrs_issue,
	output logic [1:0] emrs_odt,
	output logic emrs_weak,
	output logic emrs_fast_sr,
	output logic srex_issue,
	output logic [3:0] burst_beats
);
	logic [31:0] timing_second_r;
	logic [31:0] config_first_r;
	logic init_busy_r;
	logic srex_busy_r;
	logic init_go;
	logic srex_go;
	logic wr_acc;
	logic init_done_sys;
	logic srex_done_sys;
	logic init_go_mem;
	logic srex_go_mem;
	logic init_done_mem;
	logic srex_done_mem;
	logic [31:0] ts_m1_r;
	logic [31:0] ts_m2_r;
	logic [31:0] cf_m1_r;
	logic [31:0] cf_m2_r;
	logic [7:0] grant_cnt_r;

	function automatic logic [3:0] rfc_cycles(input logic [2:0] code);
		case (code)
			3'h0: rfc_cycles = dram_tmg_pkg::RFC0_CYC;
			3'h1: rfc_cycles = dram_tmg_pkg::RFC1_CYC;
			3'h2: rfc_cycles = dram_tmg_pkg::RFC2_CYC;
			3'h3: rfc_cycles = dram_tmg_pkg::RFC3_CYC;
			default: rfc_cycles = dram_tmg_pkg::RFC4_CYC;
		endcase
	endfunction : rfc_cycles

	assign wr_acc = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign init_go = wr_acc && (paddr == dram_tmg_pkg::OFF_CONFIG_FIRST)
		&& pwdata[dram_tmg_pkg::INIT_BIT] && !init_busy_r;
	assign srex_go = wr_acc && (paddr == dram_tmg_pkg::OFF_CONFIG_FIRST)
		&& pwdata[dram_tmg_pkg::SREX_BIT] && !srex_busy_r;

	// timing register with four refresh fields
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			timing_second_r <= dram_tmg_pkg::RST_TIMING_SECOND;
		end else if (wr_acc && paddr == dram_tmg_pkg::OFF_TIMING_SECOND) begin
			timing_second_r <= pwdata & dram_tmg_pkg::MASK_TIMING_SECOND;
		end
	end

	// config register, reserved bits held zero
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			config_first_r <= dram_tmg_pkg::RST_CONFIG_FIRST;
		end else if (wr_acc && paddr == dram_tmg_pkg::OFF_CONFIG_FIRST) begin
			config_first_r <= pwdata & dram_tmg_pkg::MASK_CONFIG_FIRST & ~32'h0000_0003;
		end
	end

	// busy until the link reports completion; done wins over nothing else
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			init_busy_r <= 1'b0;
		end else if (init_go) begin
			init_busy_r <= 1'b1;
		end else if (init_done_sys) begin
			init_busy_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			srex_busy_r <= 1'b0;
		end else if (srex_go) begin
			srex_busy_r <= 1'b1;
		end else if (srex_done_sys) begin
			srex_busy_r <= 1'b0;
		end
	end

	// read back with live command bits
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				dram_tmg_pkg::OFF_TIMING_SECOND: prdata <= timing_second_r;
				dram_tmg_pkg::OFF_CONFIG_FIRST: prdata <= config_first_r | {30'h0, srex_busy_r, init_busy_r};
				dram_tmg_pkg::OFF_SCHED_STATUS: prdata <= {24'h0, grant_cnt_r};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	cdc_pulse u_init_go (
		.src_clk(sys_clk),
		.src_rst(srst),
		.src_pulse(init_go),
		.dst_clk(mem_clk),
		.dst_rst(mem_rst),
		.dst_pulse(init_go_mem)
	);
	cdc_pulse u_srex_go (
		.src_clk(sys_clk),
		.src_rst(srst),
		.src_pulse(srex_go),
		.dst_clk(mem_clk),
		.dst_rst(mem_rst),
		.dst_pulse(srex_go_mem)
	);
	cdc_pulse u_init_done (
		.src_clk(mem_clk),
		.src_rst(mem_rst),
		.src_pulse(init_done_mem),
		.dst_clk(sys_clk),
		.dst_rst(srst),
		.dst_pulse(init_done_sys)
	);
	cdc_pulse u_srex_done (
		.src_clk(mem_clk),
		.src_rst(mem_rst),
		.src_pulse(srex_done_mem),
		.dst_clk(sys_clk),
		.dst_rst(srst),
		.dst_pulse(srex_done_sys)
	);

	// quasi-static config crossing, two flops
	always_ff @(posedge mem_clk) begin
		if (mem_rst) begin
			ts_m1_r <= 32'h0000_0000;
			ts_m2_r <= 32'h0000_0000;
			cf_m1_r <= 32'h0000_0000;
			cf_m2_r <= 32'h0000_0000;
		end else begin
			ts_m1_r <= timing_second_r;
			ts_m2_r <= ts_m1_r;
			cf_m1_r <= config_first_r;
			cf_m2_r <= cf_m1_r;
		end
	end

	// link domain
	logic [5:0] seq_cnt_r;
	dram_tmg_pkg::seq_t seq_r;
	logic [7:0] ref_cnt_r;
	logic [3:0] rfc_wait_r;
	logic [4:0] rd_gap_r;
	logic [4:0] wr_gap_r;
	logic [2:0] last_rd_cs_r;
	logic [2:0] last_wr_cs_r;
	logic [3:0] bl;
	logic [4:0] rwt_need;
	logic [3:0] wtr_need;
	logic [3:0] wrrd_need;
	logic [4:0] wrwr_need;
	logic [4:0] rdrd_need;
	logic [7:0] ref_period;
	logic [2:0] rfc_code;
	logic ok;
	logic [7:0] gcnt_m_r;

	// burst length from width and burst bit
	assign bl = (cf_m2_r[dram_tmg_pkg::WIDE_BIT] || cf_m2_r[dram_tmg_pkg::SHORT_BIT])
		? dram_tmg_pkg::BL_SHORT : dram_tmg_pkg::BL_LONG;
	// spacing counted from CAS, add BL-1 to reach last virtual clock
	assign rwt_need = {1'b0, bl} - 5'h01 + {1'b0, dram_tmg_pkg::RWT_BASE} + {2'b00, ts_m2_r[dram_tmg_pkg::RWT_LO +: 3]};
	assign wtr_need = {2'b00, ts_m2_r[dram_tmg_pkg::WTR_LO +: 2]};
	assign wrrd_need = {2'b00, ts_m2_r[dram_tmg_pkg::WRRD_LO +: 2]};
	assign wrwr_need = {1'b0, bl} - 5'h01 + {1'b0, dram_tmg_pkg::WRWR_BASE} + {3'b000, ts_m2_r[dram_tmg_pkg::WRWR_LO +: 2]};
	assign rdrd_need = {1'b0, bl} - 5'h01 + {1'b0, dram_tmg_pkg::RDRD_BASE} + {3'b000, ts_m2_r[dram_tmg_pkg::RDRD_LO +: 2]};
	assign ref_period = ts_m2_r[dram_tmg_pkg::REF_LO] ? dram_tmg_pkg::REF_39_CYC : dram_tmg_pkg::REF_78_CYC;
	// per-DIMM field picked by chip select pair
	assign rfc_code = ts_m2_r[dram_tmg_pkg::RFC_LO + dram_tmg_pkg::RFC_W * cand_cs[2:1] +: 3];

	// grant only when every spacing is met
	always_comb begin
		ok = (seq_r == dram_tmg_pkg::SEQ_IDLE);
		case (cand_cmd)
			dram_tmg_pkg::CMD_WRITE: begin
				if (rd_gap_r < rwt_need) ok = 1'b0;
				if (cand_odt_change && wr_gap_r < wrwr_need) ok = 1'b0;
			end
			dram_tmg_pkg::CMD_READ: begin
				if (cand_cs == last_wr_cs_r && wr_gap_r < {1'b0, bl} - 5'h01 + {1'b0, wtr_need}) ok = 1'b0;
				if (cand_cs[2:1] != last_wr_cs_r[2:1] && wr_gap_r < {1'b0, bl} - 5'h01 + {1'b0, wrrd_need}) ok = 1'b0;
				if (cand_cs != last_rd_cs_r && rd_gap_r < rdrd_need) ok = 1'b0;
			end
			dram_tmg_pkg::CMD_ACT: begin
				if (rfc_wait_r != 4'h0) ok = 1'b0;
			end
			dram_tmg_pkg::CMD_REF: begin
				if (rfc_wait_r != 4'h0) ok = 1'b0;
			end
			default: ok = 1'b0;
		endcase
	end
	assign cand_grant = ok;

	// gaps since last read and write CAS, saturating
	always_ff @(posedge mem_clk) begin
		if (mem_rst) begin
			rd_gap_r <= 5'h1f;
			wr_gap_r <= 5'h1f;
			last_rd_cs_r <= 3'h0;
			last_wr_cs_r <= 3'h0;
		end else begin
			rd_gap_r <= (ok && cand_cmd == dram_tmg_pkg::CMD_READ) ? 5'h01 : ((rd_gap_r == 5'h1f) ? rd_gap_r : rd_gap_r + 5'h01);
			wr_gap_r <= (ok && cand_cmd == dram_tmg_pkg::CMD_WRITE) ? 5'h01 : ((wr_gap_r == 5'h1f) ? wr_gap_r : wr_gap_r + 5'h01);
			if (ok && cand_cmd == dram_tmg_pkg::CMD_READ) last_rd_cs_r <= cand_cs;
			if (ok && cand_cmd == dram_tmg_pkg::CMD_WRITE) last_wr_cs_r <= cand_cs;
		end
	end

	always_ff @(posedge mem_clk) begin
		if (mem_rst) begin
			rfc_wait_r <= 4'h0;
		end else if (ok && cand_cmd == dram_tmg_pkg::CMD_REF) begin
			rfc_wait_r <= rfc_cycles(rfc_code) - 4'h1;
		end else if (rfc_wait_r != 4'h0) begin
			rfc_wait_r <= rfc_wait_r - 4'h1;
		end
	end

	always_ff @(posedge mem_clk) begin
		if (mem_rst) begin
			ref_cnt_r <= 8'h00;
			refresh_req <= 1'b0;
		end else if (ts_m2_r[dram_tmg_pkg::REF_OFF_BIT] || !ts_m2_r[dram_tmg_pkg::REF_LO + 1]) begin
			ref_cnt_r <= 8'h00;
			refresh_req <= 1'b0;
		end else begin
			if (ok && cand_cmd == dram_tmg_pkg::CMD_REF) refresh_req <= 1'b0;
			if (ref_cnt_r >= ref_period - 8'h01) begin
				ref_cnt_r <= 8'h00;
				refresh_req <= 1'b1;
			end else begin
				ref_cnt_r <= ref_cnt_r + 8'h01;
			end
		end
	end

	always_ff @(posedge mem_clk) begin
		if (mem_rst) begin
			seq_r <= dram_tmg_pkg::SEQ_IDLE;
			seq_cnt_r <= 6'h00;
		end else begin
			case (seq_r)
				dram_tmg_pkg::SEQ_IDLE: begin
					if (init_go_mem) begin
						seq_r <= dram_tmg_pkg::SEQ_INIT;
						seq_cnt_r <= dram_tmg_pkg::INIT_SEQ_CYC;
					end else if (srex_go_mem) begin
						seq_r <= dram_tmg_pkg::SEQ_SREX;
						seq_cnt_r <= dram_tmg_pkg::SREX_SEQ_CYC;
					end
				end
				dram_tmg_pkg::SEQ_INIT, dram_tmg_pkg::SEQ_SREX: begin
					if (seq_cnt_r == 6'h00) begin
						seq_r <= dram_tmg_pkg::SEQ_IDLE;
					end else begin
						seq_cnt_r <= seq_cnt_r - 6'h01;
					end
				end
				default: seq_r <= dram_tmg_pkg::SEQ_IDLE;
			endcase
		end
	end
	assign init_done_mem = (seq_r == dram_tmg_pkg::SEQ_INIT) && (seq_cnt_r == 6'h00);
	assign srex_done_mem = (seq_r == dram_tmg_pkg::SEQ_SREX) && (seq_cnt_r == 6'h00);

	// EMRS values from the config register
	always_ff @(posedge mem_clk) begin
		if (mem_rst) begin
			emrs_issue <= 1'b0;
			emrs_odt <= 2'b00;
			emrs_weak <= 1'b0;
			emrs_fast_sr <= 1'b0;
			srex_issue <= 1'b0;
			burst_beats <= dram_tmg_pkg::BL_LONG;
		end else begin
			emrs_issue <= (seq_r == dram_tmg_pkg::SEQ_INIT) && (seq_cnt_r == 6'h10);
			emrs_odt <= cf_m2_r[dram_tmg_pkg::ODT_LO +: 2];
			emrs_weak <= cf_m2_r[dram_tmg_pkg::WEAK_BIT];
			emrs_fast_sr <= cf_m2_r[dram_tmg_pkg::FSR_BIT];
			srex_issue <= (seq_r == dram_tmg_pkg::SEQ_SREX) && (seq_cnt_r == dram_tmg_pkg::SREX_SEQ_CYC);
			burst_beats <= bl;
		end
	end

	// grant counter, gray-free sample via slow status
	always_ff @(posedge mem_clk) begin
		if (mem_rst) begin
			gcnt_m_r <= 8'h00;
		end else if (ok && cand_cmd != dram_tmg_pkg::CMD_NONE) begin
			gcnt_m_r <= gcnt_m_r + 8'h01;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			grant_cnt_r <= 8'h00;
		end else if (init_done_sys || srex_done_sys) begin
			grant_cnt_r <= gcnt_m_r;
		end
	end

	AST_RFC_HOLD: assert property (@(posedge mem_clk) disable iff (mem_rst)
		(rfc_wait_r != 4'h0) |-> !(cand_grant && cand_cmd == dram_tmg_pkg::CMD_ACT))
		else $error("activate granted inside refresh cycle time");
	AST_RWT: assert property (@(posedge mem_clk) disable iff (mem_rst)
		(cand_grant && cand_cmd == dram_tmg_pkg::CMD_WRITE) |-> rd_gap_r >= rwt_need)
		else $error("write granted before read turnaround");
	AST_INIT_BUSY: assert property (@(posedge sys_clk) disable iff (srst)
		init_go |=> init_busy_r)
		else $error("init bit not busy after start");
	AST_REF_OFF: assert property (@(posedge mem_clk) disable iff (mem_rst)
		ts_m2_r[dram_tmg_pkg::REF_OFF_BIT] |=> !refresh_req)
		else $error("refresh requested while disabled");
	AST_WRWR: assert property (@(posedge mem_clk) disable iff (mem_rst)
		(cand_grant && cand_cmd == dram_tmg_pkg::CMD_WRITE && cand_odt_change) |-> wr_gap_r >= wrwr_need)
		else $error("write granted before terminator spacing");
	// nothing granted while a sequence runs
	AST_SEQ_HOLD: assert property (@(posedge mem_clk) disable iff (mem_rst)
		(seq_r != dram_tmg_pkg::SEQ_IDLE) |-> !cand_grant)
		else $error("command granted during init or exit sequence");
	COV_WRITE: cover property (@(posedge mem_clk) disable iff (mem_rst) cand_grant && cand_cmd == dram_tmg_pkg::CMD_WRITE);
	COV_REF: cover property (@(posedge mem_clk) disable iff (mem_rst) refresh_req);
	COV_INIT: cover property (@(posedge sys_clk) disable iff (srst) init_done_sys);
endmodule : dram_timing_refresh_config
`default_nettype wire

/* File: verification/dimm_cmd_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dimm_cmd_model (
	// link clock
	input wire logic mem_clk,
	// candidate command
	output logic [2:0] cand_cmd,
	output logic [2:0] cand_cs,
	output logic cand_odt_change,
	// scheduler answer
	input wire logic cand_grant
);
	int cyc = 0;
	int last = 0;
	initial begin
		cand_cmd = 3'h0;
		cand_cs = 3'h7;
		cand_odt_change = 1'b0;
	end
	always @(posedge mem_clk) begin
		cyc <= cyc + 1;
	end
	task automatic issue(input logic [2:0] c, input logic [2:0] s, input logic o, output int gap);
		int n;
		cand_cmd <= c;
		cand_cs <= s;
		cand_odt_change <= o;
		for (n = 0; n < 64; n++) begin
			@(negedge mem_clk);
			if (cand_grant === 1'b1) break;
		end
		@(posedge mem_clk);
		gap = (n == 64) ? -1 : cyc - last;
		last = cyc;
	endtask : issue
	// released select shows inverse
	task automatic idle();
		cand_cmd <= 3'h0;
		cand_cs <= ~cand_cs;
		cand_odt_change <= ~cand_odt_change;
	endtask : idle
endmodule : dimm_cmd_model
`default_nettype wire

/* File: verification/dram_timing_refresh_config_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module dram_timing_refresh_config_bench;
	localparam logic [11:0] tim_a = dram_tmg_pkg::OFF_TIMING_SECOND;
	localparam logic [11:0] cfg_a = dram_tmg_pkg::OFF_CONFIG_FIRST;
	logic sys_clk = 1'b0;
	logic mem_clk = 1'b0;
	logic srst = 1'b1;
	logic mem_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, r;
	logic pready, pslverr, cand_grant, cand_odt_change, refresh_req, emrs_issue, emrs_weak, emrs_fast_sr, srex_issue;
	logic [1:0] emrs_odt;
	logic [2:0] cand_cmd, cand_cs;
	logic [3:0] burst_beats;
	logic [3:0] emrs_val = 4'h0;
	int fails = 0;
	int total_checks = 0;
	int emrs_n = 0;
	int srex_n = 0;
	int g, t0, t1, k, c, d, b;
	int rfc[5] = '{1, 1, 2, 2, 3};

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		#3;
		forever #62.5 mem_clk = ~mem_clk;
	end

	dram_timing_refresh_config dut_u (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_clk(mem_clk), .mem_rst(mem_rst), .cand_cmd(cand_cmd), .cand_cs(cand_cs),
		.cand_odt_change(cand_odt_change), .cand_grant(cand_grant), .refresh_req(refresh_req),
		.emrs_issue(emrs_issue), .emrs_odt(emrs_odt), .emrs_weak(emrs_weak), .emrs_fast_sr(emrs_fast_sr),
		.srex_issue(srex_issue), .burst_beats(burst_beats));
	dimm_cmd_model partner_u (.mem_clk(mem_clk), .cand_cmd(cand_cmd), .cand_cs(cand_cs),
		.cand_odt_change(cand_odt_change), .cand_grant(cand_grant));

	always @(posedge mem_clk) begin
		if (emrs_issue === 1'b1) begin
			emrs_n <= emrs_n + 1;
			emrs_val <= {emrs_odt, emrs_weak, emrs_fast_sr};
		end
		if (srex_issue === 1'b1) begin
			srex_n <= srex_n + 1;
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic give_up();
		fails++;
		stop_test();
	endtask : give_up

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge sys_clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) give_up();
	endtask : apb

	task automatic set_cfg(input logic [31:0] v, input logic [3:0] bl);
		int n;
		apb(1'b1, cfg_a, v, r);
		for (n = 0; n < 40 && burst_beats !== bl; n++) @(posedge mem_clk);
		check({28'h0, burst_beats}, {28'h0, bl});
	endtask : set_cfg

	function automatic logic [31:0] tv(input int sh, input int code);
		return 32'h0004_0000 | (32'(code) << sh);
	endfunction : tv

	task automatic pair(input logic [2:0] c1, input logic [2:0] s1, input logic [2:0] c2, input logic [2:0] s2,
		input logic o, input logic [31:0] v, input int e);
		apb(1'b1, tim_a, v, r);
		repeat (20) @(posedge mem_clk);
		partner_u.issue(c1, s1, 1'b0, g);
		partner_u.issue(c2, s2, o, g);
		partner_u.idle();
		if (g < 0) give_up();
		check(32'(g), 32'(e));
	endtask : pair

	task automatic wait_ref(output int t);
		int n;
		for (n = 0; n < 200; n++) begin
			@(negedge mem_clk);
			if (refresh_req === 1'b1) break;
		end
		if (n == 200) give_up();
		t = partner_u.cyc;
		@(posedge mem_clk);
		partner_u.issue(dram_tmg_pkg::CMD_REF, 3'h0, 1'b0, g);
		partner_u.idle();
	endtask : wait_ref

	initial begin
		#1000000;
		give_up();
	end

	initial begin
		repeat (4) @(posedge mem_clk);
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		mem_rst <= 1'b0;
		apb(1'b0, tim_a, 32'h0, r);
		check(r, 32'h0000_0000);
		apb(1'b0, cfg_a, 32'h0, r);
		check(r, 32'h0000_0000);
		check({28'h0, burst_beats}, 32'h0000_0008);
		check({31'h0, refresh_req}, 32'h0000_0000);
		check({31'h0, pslverr}, 32'h0000_0000);
		apb(1'b1, tim_a, 32'hffff_ffff, r);
		apb(1'b1, 12'h0a0, 32'hffff_ffff, r);
		apb(1'b0, tim_a, 32'h0, r);
		check(r, 32'hfff7_ff70);
		apb(1'b1, cfg_a, 32'hffff_fffc, r);
		apb(1'b0, cfg_a, 32'h0, r);
		check(r, 32'h0009_ffb0);
		apb(1'b0, 12'h0a0, 32'h0, r);
		check(r, 32'h0000_0000);
		for (k = 0; k < 4; k++) set_cfg(32'(k) << 10, (k == 0) ? 4'h8 : 4'h4);
		for (d = 0; d < 2; d++) begin
			b = d ? 4 : 8;
			set_cfg(32'(d) << 10, 4'(b));
			for (c = 0; c < 2; c++) begin
				k = c ? 7 : 0;
				pair(dram_tmg_pkg::CMD_READ, 3'h0, dram_tmg_pkg::CMD_WRITE, 3'h0, 1'b0, tv(4, k), b + 1 + k);
				k = c ? 3 : 1;
				pair(dram_tmg_pkg::CMD_WRITE, 3'h0, dram_tmg_pkg::CMD_READ, 3'h0, 1'b0, tv(8, k), b - 1 + k);
				k = c ? 3 : 0;
				pair(dram_tmg_pkg::CMD_WRITE, 3'h0, dram_tmg_pkg::CMD_READ, 3'h2, 1'b0, tv(10, k), b - 1 + k);
				k = c ? 2 : 0;
				pair(dram_tmg_pkg::CMD_WRITE, 3'h0, dram_tmg_pkg::CMD_WRITE, 3'h1, 1'b1, tv(12, k), b + k);
				k = c ? 3 : 0;
				pair(dram_tmg_pkg::CMD_READ, 3'h0, dram_tmg_pkg::CMD_READ, 3'h1, 1'b0, tv(14, k), b + 1 + k);
			end
		end
		for (k = 0; k < 5; k++) pair(dram_tmg_pkg::CMD_REF, 3'h0, dram_tmg_pkg::CMD_ACT, 3'h0, 1'b0, tv(20, k), rfc[k]);
		for (d = 1; d < 4; d++) pair(dram_tmg_pkg::CMD_REF, 3'(2 * d), dram_tmg_pkg::CMD_ACT, 3'(2 * d), 1'b0, tv(20 + 3 * d, 4), rfc[4]);
		for (k = 0; k < 2; k++) begin
			apb(1'b1, tim_a, k ? 32'h0002_0000 : 32'h0003_0000, r);
			wait_ref(t0);
			wait_ref(t0);
			wait_ref(t1);
			check(32'(t1 - t0), k ? 32'(dram_tmg_pkg::REF_78_CYC) : 32'(dram_tmg_pkg::REF_39_CYC));
		end
		apb(1'b1, tim_a, 32'h0007_0000, r);
		repeat (10) @(posedge mem_clk);
		if (refresh_req === 1'b1) wait_ref(t0);
		c = 0;
		repeat (100) begin
			@(negedge mem_clk);
			if (refresh_req !== 1'b0) c++;
		end
		check(32'(c), 32'h0000_0000);
		apb(1'b1, cfg_a, 32'h0000_02a1, r);
		apb(1'b0, cfg_a, 32'h0, r);
		check(r, 32'h0000_02a1);
		for (k = 0; k < 300 && r[0] !== 1'b0; k++) apb(1'b0, cfg_a, 32'h0, r);
		check(r, 32'h0000_02a0);
		check(32'(emrs_n > 0), 32'h0000_0001);
		check({28'h0, emrs_val}, 32'h0000_000b);
		apb(1'b1, cfg_a, 32'h0000_02a2, r);
		apb(1'b0, cfg_a, 32'h0, r);
		check(r, 32'h0000_02a2);
		for (k = 0; k < 300 && r[1] !== 1'b0; k++) apb(1'b0, cfg_a, 32'h0, r);
		check(r, 32'h0000_02a0);
		check(32'(srex_n), 32'h0000_0001);
		stop_test();
	end
endmodule : dram_timing_refresh_config_bench
`default_nettype wire
